//--- ppo_pkg.sv
// Package for the port pin override logic: register map, field positions, reset values.
// Assumes an AXI4-Lite master with 32-bit data on a single 100 MHz clock.
// Overview of operation
// RQ1 - Sleep clamp forces digital input to ground.
// RQ2 - Enabled external interrupt pins bypass the clamp.
// RQ3 - Clamp release on high pin sets interrupt flag.
// RQ4 - No clamping in reset, active or idle.
// RQ5 - Pull-ups switched off while reset asserted.
// RQ6 - Pull-up follows override, else needs 0b010.
// RQ7 - Drive enable follows override, else direction bit.
// RQ8 - Driven level from override or output value bit.
// RQ9 - Input enable follows override, else sleep state.
// RQ10 - Schmitt tap given to peripherals unsynchronised.
// RQ11 - Peripherals generate their own per-pin overrides.
// RQ12 - Strobes per port, clamp and kill shared, overrides per pin.
// RQ13 - Special function register 8 bits, bit4 reserved.
// RQ14 - Direction selects drive, pull-up or tri-state.
// RQ15 - Sampled level through latch and register.
// RQ16 - Global pull-up kill disables every pull-up; the code leaves pins with a pull-up override on their override level.
// RQ17 - Pins tri-state as soon as reset asserts.
// RQ18 - Override selection is purely combinational.
package ppo_pkg;
	localparam int PPO_AW = 8;
	// Register byte addresses.
	localparam logic [PPO_AW-1:0] PPO_OFS_OUTVAL = 8'h00;
	localparam logic [PPO_AW-1:0] PPO_OFS_DIR = 8'h04;
	localparam logic [PPO_AW-1:0] PPO_OFS_PINLVL = 8'h08;
	localparam logic [PPO_AW-1:0] PPO_OFS_SFC = 8'h0C;
	localparam logic [PPO_AW-1:0] PPO_OFS_EXTEN = 8'h10;
	localparam logic [PPO_AW-1:0] PPO_OFS_IRQ_STAT = 8'h14;
	localparam logic [PPO_AW-1:0] PPO_OFS_IRQ_MASK = 8'h18;
	// Special function control layout.
	localparam int PPO_SFC_KILL_BIT = 2;
	localparam logic [7:0] PPO_SFC_WMASK = 8'hEF;
	localparam logic [7:0] PPO_SFC_RESET = 8'h00;
	localparam logic [7:0] PPO_PORT_RESET = 8'h00;
	localparam logic [1:0] PPO_RESP_OKAY = 2'h0;
	localparam logic [1:0] PPO_RESP_SLVERR = 2'h2;
	// Per-pin override bundle from an alternate-function module.
	typedef struct packed {
		logic pullup_override_select;
		logic pullup_override_level;
		logic drive_enable_override_select;
		logic drive_enable_override_level;
		logic output_level_override_select;
		logic output_level_override_level;
		logic input_gate_override_select;
		logic input_gate_override_level;
	} ppo_ovr_t;
	// Pad-side control bundle for one pin.
	typedef struct packed {
		logic drive_en;
		logic drive_level;
		logic pullup_en;
	} ppo_pad_t;
endpackage

//--- ppo_pin_sync.sv
// Pin input path after the sleep clamp gate: sync latch stage and sampled-level register.
// Assumes pad inputs are synchronous to sys_clk_i, so the latch is modelled as a flop.
module ppo_pin_sync
	import ppo_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Gated pad level in, sampled level out.
	input wire logic [WIDTH-1:0] gated_i,
	output logic [WIDTH-1:0] sampled_o
);
	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] latch_next;
	logic [WIDTH-1:0] sample_reg;
	logic [WIDTH-1:0] sample_next;

	// The two stages pass the level on unchanged.
	always_comb
	begin
		latch_next = gated_i;
		sample_next = latch_reg;
	end

	// Latch stage then sampled-level register.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			latch_reg <= '0;
			sample_reg <= '0;
		end
		else
		begin
			latch_reg <= latch_next; // see RQ15
			sample_reg <= sample_next;
		end
	end

	assign sampled_o = sample_reg;
endmodule

//--- ppo_port.sv
// One 8-pin port with alternate-function overrides, sleep clamp and an AXI4-Lite register file.
// Assumes overrides come from peripheral modules and pad inputs are synchronous to sys_clk_i.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
module ppo_port
	import ppo_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// AXI4-Lite write channels.
	input wire logic [PPO_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels.
	input wire logic [PPO_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Sleep controller clamp request, shared by all ports.
	input wire logic sleep_clamp_i,
	// Per-pin overrides from alternate-function modules.
	input wire ppo_ovr_t [WIDTH-1:0] ovr_i,
	// Pads.
	input wire logic [WIDTH-1:0] pad_i,
	output logic [WIDTH-1:0] pad_o,
	output logic [WIDTH-1:0] pad_oe_o,
	output logic [WIDTH-1:0] pad_pullup_o,
	// Unsynchronised Schmitt output to alternate functions.
	output logic [WIDTH-1:0] schmitt_input_tap_o,
	// Global pull-up kill for the other ports.
	output logic global_pullup_kill_o,
	// Interrupt.
	output logic irq_o
);
	// Register state.
	logic [WIDTH-1:0] pin_output_value_bit_reg, pin_output_value_bit_next;
	logic [WIDTH-1:0] pin_direction_bit_reg, pin_direction_bit_next;
	logic [7:0] sfc_reg, sfc_next;
	logic [WIDTH-1:0] exten_reg, exten_next;
	logic [WIDTH-1:0] stat_reg, stat_next;
	logic [WIDTH-1:0] mask_reg, mask_next;
	// Bus state.
	logic [PPO_AW-1:0] awaddr_reg, awaddr_next;
	logic aw_full_reg, aw_full_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic w_full_reg, w_full_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	// Pad and input path state.
	ppo_pad_t [WIDTH-1:0] pad_reg, pad_next;
	logic [WIDTH-1:0] tap_reg, tap_next;
	logic [WIDTH-1:0] gated_prev_reg, gated_prev_next;
	logic irq_reg, irq_next;
	logic [WIDTH-1:0] gated;
	logic [WIDTH-1:0] sampled;
	logic do_write;
	logic pullup_kill;

	// True when the offset names a mapped register.
	function automatic logic ppo_mapped(input logic [PPO_AW-1:0] a);
		ppo_mapped = (a == PPO_OFS_OUTVAL) || (a == PPO_OFS_DIR) || (a == PPO_OFS_PINLVL) ||
			(a == PPO_OFS_SFC) || (a == PPO_OFS_EXTEN) || (a == PPO_OFS_IRQ_STAT) ||
			(a == PPO_OFS_IRQ_MASK);
	endfunction

	assign pullup_kill = sfc_reg[PPO_SFC_KILL_BIT];
	assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

	// Per-pin override selection and input gating; purely combinational.
	for (genvar n = 0; n < WIDTH; n++)
	begin : g_pin
		logic input_en;
		always_comb
		begin
			if (ovr_i[n].pullup_override_select) // see RQ18
				pad_next[n].pullup_en = ovr_i[n].pullup_override_level; // see RQ6
			else
				pad_next[n].pullup_en = ({pin_direction_bit_reg[n], pin_output_value_bit_reg[n], pullup_kill}
					== 3'b010); // see RQ6 see RQ14 see RQ16
			pad_next[n].drive_en = ovr_i[n].drive_enable_override_select ?
				ovr_i[n].drive_enable_override_level : pin_direction_bit_reg[n]; // see RQ7 see RQ14
			pad_next[n].drive_level = ovr_i[n].output_level_override_select ?
				ovr_i[n].output_level_override_level : pin_output_value_bit_reg[n]; // see RQ8
			if (ovr_i[n].input_gate_override_select)
				input_en = ovr_i[n].input_gate_override_level; // see RQ9
			else
				input_en = !sleep_clamp_i || exten_reg[n]; // see RQ1 see RQ2 see RQ4
		end
		assign gated[n] = pad_i[n] & input_en; // see RQ1
	end

	// Input synchroniser feeding the sampled-level register.
	ppo_pin_sync #(.WIDTH(WIDTH)) u_sync
	(
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.gated_i(gated),
		.sampled_o(sampled)
	);

	// Schmitt tap, edge history and interrupt status next values.
	always_comb
	begin
		tap_next = gated; // see RQ10
		gated_prev_next = gated;
		stat_next = stat_reg;
		if (do_write && awaddr_reg == PPO_OFS_IRQ_STAT && wstrb_reg[0])
			stat_next = stat_reg & ~wdata_reg[WIDTH-1:0];
		// Set beats clear; the clamp release on a high pin is a rising edge.
		stat_next = stat_next | (gated & ~gated_prev_reg); // see RQ3
		irq_next = |(stat_next & mask_reg);
	end

	// AXI4-Lite slave next values and register writes.
	always_comb
	begin
		awaddr_next = awaddr_reg;
		aw_full_next = aw_full_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		w_full_next = w_full_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		pin_output_value_bit_next = pin_output_value_bit_reg;
		pin_direction_bit_next = pin_direction_bit_reg;
		sfc_next = sfc_reg;
		exten_next = exten_reg;
		mask_next = mask_reg;
		if (s_axi_awvalid_i && !aw_full_reg)
		begin
			awaddr_next = s_axi_awaddr_i;
			aw_full_next = 1'b1;
		end
		if (s_axi_wvalid_i && !w_full_reg)
		begin
			wdata_next = s_axi_wdata_i;
			wstrb_next = s_axi_wstrb_i;
			w_full_next = 1'b1;
		end
		if (do_write)
		begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = ppo_mapped(awaddr_reg) ? PPO_RESP_OKAY : PPO_RESP_SLVERR;
			if (wstrb_reg[0])
			begin
				case (awaddr_reg)
					PPO_OFS_OUTVAL: pin_output_value_bit_next = wdata_reg[WIDTH-1:0];
					PPO_OFS_DIR: pin_direction_bit_next = wdata_reg[WIDTH-1:0];
					PPO_OFS_SFC: sfc_next = wdata_reg[7:0] & PPO_SFC_WMASK; // see RQ13
					PPO_OFS_EXTEN: exten_next = wdata_reg[WIDTH-1:0];
					PPO_OFS_IRQ_MASK: mask_next = wdata_reg[WIDTH-1:0];
					default: ;
				endcase
			end
		end
		if (bvalid_reg && s_axi_bready_i)
			bvalid_next = 1'b0;
		if (s_axi_arvalid_i && !rvalid_reg)
		begin
			rvalid_next = 1'b1;
			rresp_next = ppo_mapped(s_axi_araddr_i) ? PPO_RESP_OKAY : PPO_RESP_SLVERR;
			rdata_next = 32'h0000_0000;
			case (s_axi_araddr_i)
				PPO_OFS_OUTVAL: rdata_next[WIDTH-1:0] = pin_output_value_bit_reg;
				PPO_OFS_DIR: rdata_next[WIDTH-1:0] = pin_direction_bit_reg;
				PPO_OFS_PINLVL: rdata_next[WIDTH-1:0] = sampled; // see RQ15
				PPO_OFS_SFC: rdata_next[7:0] = sfc_reg;
				PPO_OFS_EXTEN: rdata_next[WIDTH-1:0] = exten_reg;
				PPO_OFS_IRQ_STAT: rdata_next[WIDTH-1:0] = stat_reg;
				PPO_OFS_IRQ_MASK: rdata_next[WIDTH-1:0] = mask_reg;
				default: ;
			endcase
		end
		else if (rvalid_reg && s_axi_rready_i)
			rvalid_next = 1'b0;
	end

	// Registers; reset drops pads to tri-state with pull-ups off at once.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_output_value_bit_reg <= PPO_PORT_RESET;
			pin_direction_bit_reg <= PPO_PORT_RESET;
			sfc_reg <= PPO_SFC_RESET;
			exten_reg <= '0;
			stat_reg <= '0;
			mask_reg <= '0;
			awaddr_reg <= '0;
			aw_full_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			w_full_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= PPO_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= PPO_RESP_OKAY;
			pad_reg <= '0; // see RQ5 see RQ17
			tap_reg <= '0;
			gated_prev_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			pin_output_value_bit_reg <= pin_output_value_bit_next;
			pin_direction_bit_reg <= pin_direction_bit_next;
			sfc_reg <= sfc_next;
			exten_reg <= exten_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			awaddr_reg <= awaddr_next;
			aw_full_reg <= aw_full_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			w_full_reg <= w_full_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			pad_reg <= pad_next;
			tap_reg <= tap_next;
			gated_prev_reg <= gated_prev_next;
			irq_reg <= irq_next;
		end
	end

	// Output wiring straight from flops; strobes and clamp shared port-wide.
	for (genvar k = 0; k < WIDTH; k++)
	begin : g_out
		assign pad_oe_o[k] = pad_reg[k].drive_en; // see RQ12
		assign pad_o[k] = pad_reg[k].drive_level;
		assign pad_pullup_o[k] = pad_reg[k].pullup_en;
	end
	assign schmitt_input_tap_o = tap_reg;
	assign global_pullup_kill_o = pullup_kill;
	assign irq_o = irq_reg;
	assign s_axi_awready_o = !aw_full_reg;
	assign s_axi_wready_o = !w_full_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;
endmodule

//--- ppo_far_end.sv
// Far-side model: pad wires and the alternate-function modules feeding the overrides.
// Assumes the bench sets the external drive and the override requests.
module ppo_far_end
	import ppo_pkg::*;
(
	// Clock.
	input wire logic sys_clk_i,
	// Pad controls from the port.
	input wire logic [7:0] pad_o_i,
	input wire logic [7:0] pad_oe_i,
	input wire logic [7:0] pullup_i,
	// External drivers on the pins and the override requests.
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_lvl_i,
	input wire ppo_ovr_t [7:0] ovr_req_i,
	// Resolved pin levels and overrides.
	output logic [7:0] pad_lvl_o,
	output ppo_ovr_t [7:0] ovr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_reg = 8'hA5;
	// A released pin with no pull-up wanders each cycle.
	always_ff @(posedge sys_clk_i)
		float_reg <= ~float_reg;
	// The port wins, then the outside driver, then pull-up or float.
	assign pad_lvl_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_en_i & ext_lvl_i)
		| (~pad_oe_i & ~ext_en_i & (pullup_i | float_reg));
	// Each peripheral presents its own per-pin override pairs.
	assign ovr_o = ovr_req_i;
endmodule

//--- ppo_port_chk.sv
// Checker for the port pin block, watching its ports only.
// Assumes one clock domain and an asynchronous active-low reset.
module ppo_port_chk
	import ppo_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Watched inputs.
	input wire logic sleep_clamp_i,
	input wire ppo_ovr_t [WIDTH-1:0] ovr_i,
	input wire logic [WIDTH-1:0] pad_i,
	input wire logic s_axi_bready_i,
	// Watched outputs.
	input wire logic [WIDTH-1:0] pad_o,
	input wire logic [WIDTH-1:0] pad_oe_o,
	input wire logic [WIDTH-1:0] pad_pullup_o,
	input wire logic [WIDTH-1:0] schmitt_input_tap_o,
	input wire logic global_pullup_kill_o,
	input wire logic s_axi_bvalid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	ppo_ovr_t o0;
	// Pin zero stands for all pins.
	assign o0 = ovr_i[0];
	property p_rst; disable iff (1'b0) !nrst_i |-> pad_oe_o == '0 && pad_pullup_o == '0; endproperty
	a_rst: assert property (p_rst)
		else $error("pads active in reset");
	property p_drv; $past(nrst_i && o0.drive_enable_override_select)
		|-> pad_oe_o[0] == $past(o0.drive_enable_override_level); endproperty
	a_drv: assert property (p_drv)
		else $error("drive override ignored");
	property p_val; $past(nrst_i && o0.output_level_override_select) && pad_oe_o[0]
		|-> pad_o[0] == $past(o0.output_level_override_level); endproperty
	a_val: assert property (p_val)
		else $error("level override ignored");
	property p_pu; $past(nrst_i && o0.pullup_override_select)
		|-> pad_pullup_o[0] == $past(o0.pullup_override_level); endproperty
	a_pu: assert property (p_pu)
		else $error("pull-up override ignored");
	property p_kill; $past(nrst_i && global_pullup_kill_o && !o0.pullup_override_select)
		|-> !pad_pullup_o[0]; endproperty
	a_kill: assert property (p_kill)
		else $error("pull-up on despite kill");
	property p_gate; $past(nrst_i && o0.input_gate_override_select)
		|-> schmitt_input_tap_o[0] == $past(pad_i[0] && o0.input_gate_override_level); endproperty
	a_gate: assert property (p_gate)
		else $error("input gate override ignored");
	property p_awake; $past(nrst_i && !o0.input_gate_override_select && !sleep_clamp_i)
		|-> schmitt_input_tap_o[0] == $past(pad_i[0]); endproperty
	a_awake: assert property (p_awake)
		else $error("input gated while awake");
	property p_bdone; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
	a_bdone: assert property (p_bdone)
		else $error("write answer repeated");
	c_drv: cover property (o0.drive_enable_override_select);
	c_wake: cover property ($fell(sleep_clamp_i));
	c_kill: cover property (global_pullup_kill_o);
endmodule
bind ppo_port ppo_port_chk #(.WIDTH(WIDTH)) chk_u (.sys_clk_i, .nrst_i, .sleep_clamp_i, .ovr_i, .pad_i,
	.s_axi_bready_i, .pad_o, .pad_oe_o, .pad_pullup_o, .schmitt_input_tap_o, .global_pullup_kill_o, .s_axi_bvalid_o);

//--- ppo_port_tb.sv
// Self-checking bench for the port pin block.
// Assumes the far-side model and the checker are compiled alongside.
module ppo_port_tb
	import ppo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, awvalid, wvalid, arvalid, clamp, awready, wready, bvalid, arready, rvalid, kill, irq;
	logic [7:0] awaddr, araddr, wdata8, ext_en, ext_lvl, pad_lvl, pad_o, pad_oe, pad_pu, tap, d, v;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] strb;
	logic [33:0] exp_q[$];
	ppo_ovr_t [7:0] ovr_req, ovr;
	int err_count, checks_done;
	// Free-running 100 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	ppo_port #(.WIDTH(8)) dut_u (.sys_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i({24'h0, wdata8}),
		.s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(1'b1), .sleep_clamp_i(clamp), .ovr_i(ovr), .pad_i(pad_lvl), .pad_o(pad_o),
		.pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .schmitt_input_tap_o(tap), .global_pullup_kill_o(kill),
		.irq_o(irq));
	ppo_far_end far_u (.sys_clk_i(clk), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .pullup_i(pad_pu),
		.ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .ovr_req_i(ovr_req), .pad_lvl_o(pad_lvl), .ovr_o(ovr));
	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Prints the verdict and stops.
	task automatic end_sim();
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Builds an OKAY read answer.
	function automatic logic [33:0] ok(input logic [7:0] x);
		return {PPO_RESP_OKAY, 24'h0, x};
	endfunction
	// One register write; a lost answer ends the run.
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		int n;
		awaddr <= a;
		wdata8 <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 40 && !(n > 0 && bvalid); n++)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		chk({32'h0, bresp}, {32'h0, PPO_RESP_OKAY});
		if (n == 40)
		begin
			err_count++;
			end_sim();
		end
	endtask
	// One register read; the monitor compares the answer.
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 40 && !(n > 0 && rvalid); n++)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		if (n == 40)
		begin
			err_count++;
			end_sim();
		end
	endtask
	// Works out the pad controls; struct bits 7..0 are pull-up, drive, level, input pairs.
	task automatic pads(input logic [7:0] dir, input logic [7:0] ov, input logic k);
		logic [7:0] oe, lv, pu;
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 8; i++)
		begin
			oe[i] = ovr_req[i][5] ? ovr_req[i][4] : dir[i];
			lv[i] = ovr_req[i][3] ? ovr_req[i][2] : ov[i];
			pu[i] = ovr_req[i][7] ? ovr_req[i][6] : ({dir[i], ov[i], k} == 3'b010);
		end
		chk({10'h0, pad_oe, pad_o & oe, pad_pu}, {10'h0, oe, lv & oe, pu});
		@(posedge clk);
	endtask
	// Compares every read answer with the oldest expectation.
	always @(posedge clk)
		if (rvalid)
			chk({rresp, rdata}, exp_q.pop_front());
	// Main sequence.
	initial
	begin
		{awvalid, wvalid, arvalid, clamp} = '0;
		{awaddr, araddr, wdata8, ext_lvl, ovr_req} = '0;
		ext_en = 8'hFF;
		strb = 4'hF;
		nrst = 1'b1;
		// A clean falling edge lets every port flop see the asynchronous reset.
		#1;
		nrst = 1'b0;
		void'($urandom(32'h60FB));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(PPO_OFS_SFC, ok(PPO_SFC_RESET));
		rd(8'h40, {PPO_RESP_SLVERR, 32'h0});
		wr(PPO_OFS_SFC, 8'hFF);
		rd(PPO_OFS_SFC, ok(8'hEF));
		// A write with its low byte strobe clear must leave the register alone.
		strb <= 4'h0;
		wr(PPO_OFS_SFC, 8'h00);
		strb <= 4'hF;
		rd(PPO_OFS_SFC, ok(8'hEF));
		chk({33'h0, kill}, 34'h1);
		wr(PPO_OFS_OUTVAL, 8'hFF);
		pads(8'h00, 8'hFF, 1'b1);
		wr(PPO_OFS_SFC, 8'h00);
		pads(8'h00, 8'hFF, 1'b0);
		ext_en <= 8'h00;
		repeat (3) @(posedge clk);
		rd(PPO_OFS_PINLVL, ok(8'hFF));
		ext_en <= 8'hFF;
		for (int k = 0; k < 12; k++)
		begin
			d = 8'($urandom);
			v = 8'($urandom);
			if (k > 3)
				ovr_req <= {$urandom, $urandom};
			wr(PPO_OFS_DIR, d);
			wr(PPO_OFS_OUTVAL, v);
			pads(d, v, 1'b0);
		end
		ovr_req <= '0;
		wr(PPO_OFS_DIR, 8'hFF);
		repeat (3) @(posedge clk);
		rd(PPO_OFS_PINLVL, ok(v));
		wr(PPO_OFS_DIR, 8'h00);
		ext_lvl <= 8'hFF;
		wr(PPO_OFS_EXTEN, 8'h0F);
		clamp <= 1'b1;
		repeat (3) @(posedge clk);
		rd(PPO_OFS_PINLVL, ok(8'h0F));
		wr(PPO_OFS_IRQ_STAT, 8'hFF);
		wr(PPO_OFS_IRQ_MASK, 8'hFF);
		rd(PPO_OFS_IRQ_STAT, ok(8'h00));
		clamp <= 1'b0;
		repeat (3) @(posedge clk);
		rd(PPO_OFS_IRQ_STAT, ok(8'hF0));
		chk({33'h0, irq}, 34'h1);
		wr(PPO_OFS_IRQ_MASK, 8'h00);
		repeat (2) @(posedge clk);
		chk({33'h0, irq}, 34'h0);
		wr(PPO_OFS_IRQ_STAT, 8'hF0);
		rd(PPO_OFS_IRQ_STAT, ok(8'h00));
		d = 8'($urandom);
		ext_lvl <= d;
		ovr_req <= {8{8'h03}};
		clamp <= 1'b1;
		repeat (3) @(posedge clk);
		rd(PPO_OFS_PINLVL, ok(d));
		ovr_req <= '0;
		wr(PPO_OFS_OUTVAL, 8'hFF);
		@(posedge clk);
		nrst <= 1'b0;
		#1;
		chk({18'h0, pad_oe, pad_pu}, 34'h0);
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(PPO_OFS_OUTVAL, ok(PPO_PORT_RESET));
		@(posedge clk);
		end_sim();
	end
endmodule
